/* File: dbf_flush_ctrl.sv */
`timescale 1ns/1ps
// ********************************************************************
// Data buffer flush control with APB register slave
// ********************************************************************
// Overview of operation
// - Full flush discards every buffer entry.
// - Full flush synchronously resets pointers and state.
// - Packet flush drops only the head packet.
// - Bits 4n+1 full, 4n packet; bit 20.
// - Bits 4n+3 ignore writes, read zero; reset zero.
module dbf_flush_ctrl
   import dbf_pkg::*;
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic                           pready,
   output logic [31:0]                    prdata,
   output logic                           pslverr,
   input  wire dbf_word_s [NUM_PKT_BUF-1:0] wr_word,
   output logic [NUM_PKT_BUF-1:0]         wr_ready,
   input  wire logic [NUM_PKT_BUF-1:0]    rd_ready,
   output dbf_word_s [NUM_PKT_BUF-1:0]    rd_word
);

   // ********************************************************************
   // Register access
   // ********************************************************************
   dbf_cmd_s         cmd_q;
   logic             wr_hit;
   logic             rd_acc;
   logic [CNT_W-1:0] lvl [NUM_PKT_BUF];
   logic [31:0]      status;
   logic             wr_ready_int [NUM_PKT_BUF];
   dbf_word_s        rd_word_int [NUM_PKT_BUF];

   function automatic logic cmd_bit(input logic [31:0] d, input int unsigned pos);
      return d[pos];
   endfunction : cmd_bit

   // A command is captured only at the edge that completes the access; the buffer flushes at the next edge.
   assign wr_hit = psel && penable && pready && pwrite && (paddr == FLUSH_CTRL_OFFSET);
   assign rd_acc = psel && penable && !pwrite;

   always_comb begin
      status = '0;
      for (int i = 0; i < NUM_PKT_BUF; i++) begin
         status[i] = (lvl[i] == '0);
         status[8 + i] = (lvl[i] == CNT_W'(BUF_DEPTH));
      end
   end

   // Flush pulses last exactly one cycle; no storage is kept for them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_q <= '0;
      end else begin
         for (int n = 0; n < NUM_FULL_BUF; n++) begin
            cmd_q.full_flush[n] <= wr_hit &&
               cmd_bit(pwdata, BUF_STRIDE * n + FULL_FLUSH_POS);
         end
         for (int n = 0; n < NUM_PKT_BUF; n++) begin
            cmd_q.pkt_flush[n] <= wr_hit &&
               cmd_bit(pwdata, BUF_STRIDE * n + PKT_FLUSH_POS);
         end
      end
   end

   // Zero-wait slave: pready comes from a flop set in the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && (paddr != FLUSH_CTRL_OFFSET) &&
                    (paddr != BUF_STATUS_OFFSET);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= FLUSH_CTRL_RESET;
      end else if (psel && !penable && !pwrite) begin
         // The control word always reads zero; reserved and command bits alike.
         prdata <= (paddr == BUF_STATUS_OFFSET) ? status : FLUSH_CTRL_RESET;
      end else if (rd_acc) begin
         prdata <= prdata;
      end
   end

   // ********************************************************************
   // Buffers
   // ********************************************************************
   for (genvar g = 0; g < NUM_PKT_BUF; g++) begin : g_buf
      logic ff;
      if (g < NUM_FULL_BUF) begin : g_ff
         assign ff = cmd_q.full_flush[g];
      end else begin : g_noff
         assign ff = 1'b0;
      end
      dbf_buffer u_buf (
         .pclk       (pclk),
         .presetn    (presetn),
         .full_flush (ff),
         .pkt_flush  (cmd_q.pkt_flush[g]),
         .wr_word    (wr_word[g]),
         .wr_ready   (wr_ready_int[g]),
         .rd_ready   (rd_ready[g]),
         .rd_word    (rd_word_int[g]),
         .level      (lvl[g])
      );
      assign wr_ready[g] = wr_ready_int[g];
      assign rd_word[g]  = rd_word_int[g];
   end

endmodule : dbf_flush_ctrl

/* File: dbf_pkg.sv */
// ********************************************************************
// Shared constants and types
// ********************************************************************
package dbf_pkg;

   localparam int unsigned NUM_FULL_BUF   = 5;
   localparam int unsigned NUM_PKT_BUF    = 6;
   localparam int unsigned BUF_STRIDE     = 4;
   localparam int unsigned FULL_FLUSH_POS = 1;
   localparam int unsigned PKT_FLUSH_POS  = 0;
   localparam int unsigned BUF_DEPTH      = 16;
   localparam int unsigned PTR_W          = 4;
   localparam int unsigned CNT_W          = 5;
   localparam int unsigned DATA_W         = 32;

   localparam logic [11:0] FLUSH_CTRL_OFFSET = 12'h140;
   localparam logic [11:0] BUF_STATUS_OFFSET = 12'h144;
   localparam logic [31:0] FLUSH_CTRL_RESET  = 32'h00000000;

   typedef struct packed {
      logic              valid;
      logic              last;
      logic [DATA_W-1:0] data;
   } dbf_word_s;

   typedef struct packed {
      logic [NUM_FULL_BUF-1:0] full_flush;
      logic [NUM_PKT_BUF-1:0]  pkt_flush;
   } dbf_cmd_s;

endpackage : dbf_pkg

/* File: dbf_buffer.sv */
`timescale 1ns/1ps
// ********************************************************************
// One packet data buffer with full and head-packet flush
// ********************************************************************
module dbf_buffer
   import dbf_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       full_flush,
   input  wire logic       pkt_flush,
   input  wire dbf_word_s  wr_word,
   output logic            wr_ready,
   input  wire logic       rd_ready,
   output dbf_word_s       rd_word,
   output logic [CNT_W-1:0] level
);

   typedef enum logic [0:0] {DBF_IDLE, DBF_DROP} dbf_drop_e;

   logic [DATA_W:0]  mem_q [BUF_DEPTH];
   logic [PTR_W-1:0] wptr_q;
   logic [PTR_W-1:0] rptr_q;
   logic [CNT_W-1:0] cnt_q;
   dbf_drop_e        st_q;
   logic             push;
   logic             pop;
   logic             drop_last;

   // Writes stay open while a head packet is dropped, so a packet whose tail
   // has not arrived yet cannot leave the buffer stuck in the drop state.
   assign wr_ready  = (cnt_q != CNT_W'(BUF_DEPTH));
   assign push      = wr_word.valid && wr_ready;
   assign drop_last = mem_q[rptr_q][DATA_W];
   // Dropping words is just a pop that nobody consumes.
   assign pop       = (cnt_q != '0) &&
                      ((st_q == DBF_DROP) || (rd_ready && st_q == DBF_IDLE));
   assign rd_word.valid = (cnt_q != '0) && (st_q == DBF_IDLE);
   assign rd_word.last  = mem_q[rptr_q][DATA_W];
   assign rd_word.data  = mem_q[rptr_q][DATA_W-1:0];
   assign level         = cnt_q;

   always_ff @(posedge pclk) begin
      if (push) begin
         mem_q[wptr_q] <= {wr_word.last, wr_word.data};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end else if (full_flush) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end else begin
         if (push) begin
            wptr_q <= wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= rptr_q + 1'b1;
         end
         cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= DBF_IDLE;
      end else if (full_flush) begin
         st_q <= DBF_IDLE;
      end else begin
         unique case (st_q)
            DBF_IDLE: begin
               if (pkt_flush && cnt_q != '0) begin
                  st_q <= DBF_DROP;
               end
            end
            DBF_DROP: begin
               if (pop && drop_last) begin
                  st_q <= DBF_IDLE;
               end
            end
         endcase
      end
   end

endmodule : dbf_buffer

/* File: dbf_flush_ctrl_asserts.sv */
`timescale 1ns/1ps
// ********
// Checker
// ********
module dbf_flush_ctrl_asserts
   import dbf_pkg::*;
(
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [11:0]                 paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic                        pready,
   input wire logic [31:0]                 prdata,
   input wire logic [NUM_PKT_BUF-1:0]      wr_ready,
   input wire logic [NUM_PKT_BUF-1:0]      rd_ready,
   input wire dbf_word_s [NUM_PKT_BUF-1:0] rd_word
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire acc = psel && penable && pready && paddr == 12'h140;
   wire wr  = acc && pwrite;
   wire rd  = acc && !pwrite;
   for (genvar n = 0; n < NUM_FULL_BUF; n++) begin : g_full
      AST_FULL_EMPTIES: assert property (wr && pwdata[4*n+1] |-> ##2 !rd_word[n].valid)
         else $error("full flush left data behind");
      AST_FULL_REOPENS: assert property (wr && pwdata[4*n+1] |-> ##2 wr_ready[n])
         else $error("full flush did not reopen the buffer");
   end
   // A bound is needed because a head packet may span the whole buffer.
   AST_PKT_HEAD_DROP: assert property (wr && pwdata[20] && rd_word[5].valid
      |-> ##[2:18] (!rd_word[5].valid || $changed(rd_word[5].data)))
      else $error("packet flush left the head word");
   AST_OTHER_BITS_KEEP: assert property (wr && pwdata[1:0] == 2'h0 && rd_word[0].valid
      && !rd_ready[0] |=> ##1 rd_word[0].valid)
      else $error("unrelated write emptied buffer zero");
   AST_RSVD_READ_ZERO: assert property (rd |-> (prdata & 32'h00088888) == 32'h0)
      else $error("reserved bit read back as one");
   AST_CMD_NOT_KEPT: assert property (wr ##[2:4] rd |-> prdata == 32'h0)
      else $error("command bits were retained");
endmodule : dbf_flush_ctrl_asserts

bind dbf_flush_ctrl dbf_flush_ctrl_asserts u_chk (.*);

/* File: tb_data_buffer_flush_control.sv */
`timescale 1ns/1ps
// ********
// Bench
// ********
module tb_data_buffer_flush_control;
   import dbf_pkg::*;
   logic                        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic                        pready, pslverr;
   logic [11:0]                 paddr = '0;
   logic [31:0]                 pwdata = '0, prdata, d;
   logic [NUM_PKT_BUF-1:0]      wr_ready, rd_ready = '0;
   dbf_word_s [NUM_PKT_BUF-1:0] wr_word = '0, rd_word;
   logic [32:0]                 exp_q[$], e;
   int                          mismatches = 0, n_compared = 0, cyc = 0;
   dbf_flush_ctrl uut (.*);
   initial forever #4 pclk = ~pclk;
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (!pready);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(logic [11:0] a, logic [32:0] x);
      exp_q.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic push(int n, logic [31:0] v, logic l);
      wr_word[n] <= '{1'b1, l, v};
      do @(posedge pclk); while (!wr_ready[n]);
      wr_word[n] <= '0;
      @(posedge pclk);
   endtask : push
   task automatic pop(int n, logic [31:0] v);
      exp_q.push_back({1'b0, v});
      rd_ready[n] <= 1'b1;
      @(posedge pclk);
      rd_ready[n] <= 1'b0;
      @(posedge pclk);
   endtask : pop
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         e = exp_q.pop_front();
         if (e[32]) chk("error flag", {31'h0, pslverr}, 32'h1);
         else chk("read data", prdata, e[31:0]);
      end
      for (int i = 0; i < NUM_PKT_BUF; i++)
         if (rd_ready[i]) begin
            e = exp_q.pop_front();
            chk("head word", rd_word[i].valid ? rd_word[i].data : ~e[31:0], e[31:0]);
         end
   end
   // The whole run needs well under a thousand cycles.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(71570));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h140, 33'h0);
      rd(12'h144, 33'h3F);
      rd(12'h148, 33'h1_0000_0000);
      $display("test reset done");
      d = $urandom;
      push(5, d, 1'b0);
      push(5, ~d, 1'b1);
      for (int n = 0; n < NUM_FULL_BUF; n++) begin
         push(n, $urandom, 1'b0);
         push(n, $urandom, 1'b1);
         apb(1'b1, 12'h140, $urandom & 32'h00088888);
         rd(12'h144, 33'h1F ^ (33'h1 << n));
         apb(1'b1, 12'h140, 32'h1 << (4 * n + 1));
         rd(12'h144, 33'h1F);
         rd(12'h140, 33'h0);
         push(n, d, 1'b1);
         pop(n, d);
      end
      $display("test full flush done");
      push(5, d + 32'h1, 1'b0);
      push(5, d + 32'h2, 1'b1);
      apb(1'b1, 12'h140, 32'h00100000);
      rd(12'h144, 33'h1F);
      pop(5, d + 32'h1);
      pop(5, d + 32'h2);
      rd(12'h144, 33'h3F);
      $display("test packet flush done");
      give_verdict();
   end
endmodule : tb_data_buffer_flush_control
